// [verif/bsp_ctrl_model.sv]
// controller model driving the test pins
`timescale 1ns/100ps
`default_nettype none
module bsp_ctrl_model #(
  parameter int BSR_LEN = 8
) (
  // pacing clock and test pins
  input wire logic clk,
  output logic     tck = 1'b0,
  output logic     tms = 1'b1,
  output logic     tms_driven = 1'b0,
  output logic     tdi = 1'b0,
  output logic     tdi_driven = 1'b0,
  input wire logic tdo
);
  // ----------------------------------------
  // released lines carry a changing pattern
  // ----------------------------------------
  // released pins float
  always @(negedge clk) begin
    if (!tdi_driven) tdi <= ~tdi;
    if (!tms_driven) tms <= ~tms;
  end
  // one tck period of 8 clocks, tdo taken before the fall
  task automatic pulse(output logic q);
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    q = tdo;
    tck <= 1'b0;
  endtask : pulse
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    tms_driven <= 1'b1;
    tdi_driven <= 1'b1;
    pulse(q);
  endtask : step
  task automatic scan(input logic ir, input logic [BSR_LEN-1:0] din, input int n,
                      output logic [BSR_LEN-1:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    tms_driven <= 1'b0;
    tdi_driven <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : scan
  // five rises with tms left to the pull-up, then idle
  task automatic reset_tap();
    logic q;
    repeat (5) pulse(q);
    step(1'b0, 1'b0, q);
    tms_driven <= 1'b0;
    @(posedge clk);
  endtask : reset_tap
endmodule : bsp_ctrl_model
`default_nettype wire

// [verif/bsp_port_asserts.sv]
// checker for the boundary-scan test port
`timescale 1ns/100ps
`default_nettype none
module bsp_port_asserts #(
  parameter int BSR_LEN = 8
) (
  // clock, reset, test pins
  input wire logic               CLK_SYS,
  input wire logic               RST,
  input wire logic               TCK,
  input wire logic               TMS,
  input wire logic               TMS_DRIVEN,
  input wire logic               TDO,
  input wire logic               TDO_OE,
  // device pins and snapshots
  input wire logic [BSR_LEN-1:0] CORE_OUT,
  input wire logic [BSR_LEN-1:0] PIN_OUT,
  input wire logic               EXTEST_ACTIVE,
  input wire logic [BSR_LEN-1:0] SNAP_DATA,
  input wire logic               SNAP_VALID,
  input wire logic               SNAP_READY,
  input wire logic               SNAP_LOST
);
  // ----------------------------------------
  // tck rises seen with tms high or undriven, saturating
  // ----------------------------------------
  logic       tck_d_reg;
  logic [2:0] hi_reg;
  logic [2:0] hi_next;
  assign hi_next = !(TMS | !TMS_DRIVEN) ? 3'h0 : (hi_reg == 3'h7) ? 3'h7 : hi_reg + 3'h1;
  always_ff @(posedge CLK_SYS) begin
    tck_d_reg <= TCK;
    if (RST) hi_reg <= 3'h0;
    else if (TCK && !tck_d_reg) hi_reg <= hi_next;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence snap_stall;
    SNAP_VALID && !SNAP_READY;
  endsequence
  sequence core_path;
    !EXTEST_ACTIVE && !$past(EXTEST_ACTIVE) && !$past(EXTEST_ACTIVE, 2) && !$past(RST);
  endsequence
  chk_reset_state:
    assert property ($fell(RST) |-> !TDO_OE && !EXTEST_ACTIVE && !SNAP_VALID && !SNAP_LOST)
    else $error("state after reset wrong");
  chk_core_pass:
    assert property (core_path |-> PIN_OUT == $past(CORE_OUT)) else $error("pins lost core");
  chk_snap_hold:
    assert property (snap_stall |=> SNAP_VALID && $stable(SNAP_DATA)) else $error("snap moved");
  chk_lost_sticky:
    assert property (SNAP_LOST |=> SNAP_LOST) else $error("lost flag dropped");
  chk_lost_cause:
    assert property ($rose(SNAP_LOST) |-> $past(SNAP_VALID)) else $error("lost without data");
  chk_tdo_after_fall:
    assert property ($changed(TDO) |-> !$past(TCK) && !$past(TCK, 2)) else $error("tdo off fall");
  chk_tms_reset:
    assert property ($rose(hi_reg == 3'h5) |-> ##[1:6] !EXTEST_ACTIVE)
    else $error("high tms kept extest");
  chk_ir_stable:
    assert property (TDO_OE |-> $stable(EXTEST_ACTIVE)) else $error("mode moved in shift");
endmodule : bsp_port_asserts
bind bsp_port bsp_port_asserts #(.BSR_LEN(BSR_LEN)) asserts_u (
  .CLK_SYS(CLK_SYS), .RST(RST), .TCK(TCK), .TMS(TMS), .TMS_DRIVEN(TMS_DRIVEN), .TDO(TDO),
  .TDO_OE(TDO_OE), .CORE_OUT(CORE_OUT), .PIN_OUT(PIN_OUT), .EXTEST_ACTIVE(EXTEST_ACTIVE),
  .SNAP_DATA(SNAP_DATA), .SNAP_VALID(SNAP_VALID), .SNAP_READY(SNAP_READY),
  .SNAP_LOST(SNAP_LOST));
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
`default_nettype none
`include "bsp_consts.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %0t: got %h want %h", $time, a, e); end end
module testbench;
  localparam int N = 8;
  typedef struct {logic [2:0] op; logic [N-1:0] dout; logic ext;} bsp_row_t;
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  logic         tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, ext, s_valid, s_lost;
  logic         s_ready = 1'b0;
  logic [N-1:0] pin_in = 8'hc3;
  logic [N-1:0] core_out = 8'h0f;
  logic [N-1:0] pin_out, s_data, dout;
  int           n_errors = 0;
  int           n_tests = 0;
  int           cnt;
  bsp_row_t     rows [4] = '{'{`BSP_OP_BYPASS, 8'hb4, 1'b0}, '{3'h3, 8'hb4, 1'b0},
                             '{`BSP_OP_SAMPLE, 8'hc3, 1'b0}, '{`BSP_OP_EXTEST, 8'hc3, 1'b1}};
  always #12.5 clk_sys = ~clk_sys;
  bsp_port #(.BSR_LEN(N)) dut_u (
    .CLK_SYS(clk_sys), .RST(rst), .TCK(tck), .TMS(tms), .TMS_DRIVEN(tms_drv), .TDI(tdi),
    .TDI_DRIVEN(tdi_drv), .TDO(tdo), .TDO_OE(tdo_oe), .PIN_IN(pin_in), .CORE_OUT(core_out),
    .PIN_OUT(pin_out), .EXTEST_ACTIVE(ext), .SNAP_DATA(s_data), .SNAP_VALID(s_valid),
    .SNAP_READY(s_ready), .SNAP_LOST(s_lost));
  bsp_ctrl_model #(.BSR_LEN(N)) ctrl_u (
    .clk(clk_sys), .tck(tck), .tms(tms), .tms_driven(tms_drv), .tdi(tdi),
    .tdi_driven(tdi_drv), .tdo(tdo));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // watchdog well past the expected run
  initial begin
    #500000;
    n_errors++;
    stop_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    ctrl_u.reset_tap();
    foreach (rows[i]) begin
      ctrl_u.scan(1'b1, {5'h00, rows[i].op}, 3, dout);
      `CHK(dout[2:0], 3'h1)
      `CHK(ext, rows[i].ext)
      ctrl_u.scan(1'b0, 8'h5a, N, dout);
      `CHK(dout, rows[i].dout)
      `CHK(pin_out, rows[i].ext ? 8'h5a : core_out)
      $display("row %0d done", i);
    end
    // two row captures plus fifteen fill queue and output stage; one more is lost
    ctrl_u.scan(1'b1, {5'h00, `BSP_OP_SAMPLE}, 3, dout);
    repeat (15) ctrl_u.scan(1'b0, 8'h00, N, dout);
    `CHK(s_lost, 1'b0)
    ctrl_u.scan(1'b0, 8'h00, N, dout);
    `CHK(s_lost, 1'b1)
    s_ready <= 1'b1;
    cnt = 0;
    repeat (40) begin
      @(posedge clk_sys);
      if (s_valid === 1'b1) begin
        cnt++;
        `CHK(s_data, pin_in)
      end
    end
    `CHK(cnt, `BSP_FIFO_DEPTH + 1)
    $display("queue test done");
    // reset in mid-run under external test
    ctrl_u.scan(1'b1, {5'h00, `BSP_OP_EXTEST}, 3, dout);
    `CHK(ext, 1'b1)
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK(ext, 1'b0)
    `CHK(s_lost, 1'b0)
    `CHK(pin_out, core_out)
    `CHK(tdo_oe, 1'b0)
    // back to idle, load external test, then floating tms leaves it
    ctrl_u.reset_tap();
    ctrl_u.scan(1'b1, {5'h00, `BSP_OP_EXTEST}, 3, dout);
    `CHK(ext, 1'b1)
    ctrl_u.reset_tap();
    `CHK(ext, 1'b0)
    $display("reset test done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire

// [verilog/bsp_consts.svh]
// constants of the boundary-scan test port
`ifndef BSP_CONSTS_SVH
`define BSP_CONSTS_SVH
`define BSP_IR_LEN        3
`define BSP_BSR_LEN       522
`define BSP_OP_EXTEST     3'h0
`define BSP_OP_SAMPLE     3'h5
`define BSP_OP_BYPASS     3'h7
`define BSP_IR_CAPTURE    3'h1
`define BSP_FIFO_DEPTH    16
`endif

// [verilog/bsp_fifo.sv]
// small flip-flop fifo for captured pin words
`timescale 1ns/100ps
`default_nettype none
module bsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // honest flags
  assign in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];

  // storage and pointers
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : bsp_fifo
`default_nettype wire

// [verilog/bsp_pkg.sv]
// types of the boundary-scan test port
`default_nettype none
package bsp_pkg;
  // tap controller states, one-hot
  typedef enum logic [15:0] {
    BSP_RESET   = 16'h0001,
    BSP_IDLE    = 16'h0002,
    BSP_SEL_DR  = 16'h0004,
    BSP_CAP_DR  = 16'h0008,
    BSP_SH_DR   = 16'h0010,
    BSP_EX1_DR  = 16'h0020,
    BSP_PAU_DR  = 16'h0040,
    BSP_EX2_DR  = 16'h0080,
    BSP_UPD_DR  = 16'h0100,
    BSP_SEL_IR  = 16'h0200,
    BSP_CAP_IR  = 16'h0400,
    BSP_SH_IR   = 16'h0800,
    BSP_EX1_IR  = 16'h1000,
    BSP_PAU_IR  = 16'h2000,
    BSP_EX2_IR  = 16'h4000,
    BSP_UPD_IR  = 16'h8000
  } bsp_state_t;
endpackage : bsp_pkg
`default_nettype wire

// [verilog/bsp_port.sv]
// boundary-scan test port: tap controller, instruction, bypass and boundary registers
//
// What this block does
// - instruction register is three bits; controller shifts three-bit words.
// - bypass selects one-bit register between serial input and output.
// - sample/preload captures pins unobtrusively and loads a pattern for later.
// - external test drives update contents out and captures input pins.
// - boundary length is a parameter, 522 cells by default; the bench uses 8.
// - undriven test inputs read as high, as with a weak pull-up.
`timescale 1ns/100ps
`default_nettype none
`include "bsp_consts.svh"
module bsp_port #(
  parameter int             BSR_LEN   = `BSP_BSR_LEN,
  parameter logic [2:0]     OP_EXTEST = `BSP_OP_EXTEST,
  parameter logic [2:0]     OP_SAMPLE = `BSP_OP_SAMPLE,
  parameter logic [2:0]     OP_BYPASS = `BSP_OP_BYPASS,
  parameter int             FIFO_DEPTH = `BSP_FIFO_DEPTH
) (
  // system
  input  wire logic                CLK_SYS,
  input  wire logic                RST,
  // test pins, with their undriven flags
  input  wire logic                TCK,
  input  wire logic                TMS,
  input  wire logic                TMS_DRIVEN,
  input  wire logic                TDI,
  input  wire logic                TDI_DRIVEN,
  output logic                     TDO,
  output logic                     TDO_OE,
  // device pins seen by the boundary cells
  input  wire logic [BSR_LEN-1:0]  PIN_IN,
  input  wire logic [BSR_LEN-1:0]  CORE_OUT,
  output logic [BSR_LEN-1:0]       PIN_OUT,
  output logic                     EXTEST_ACTIVE,
  // captured snapshot stream, one word per capture
  output logic [BSR_LEN-1:0]       SNAP_DATA,
  output logic                     SNAP_VALID,
  input  wire logic                SNAP_READY,
  output logic                     SNAP_LOST
);
  import bsp_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and tck edge detect
  // ----------------------------------------------------------------
  logic [1:0] tck_s;
  logic [1:0] tms_s;
  logic [1:0] tdi_s;
  logic       tck_d;
  logic       tck_rise;
  logic       tck_fall;
  wire        tms_pin = TMS_DRIVEN ? TMS : 1'b1;
  wire        tdi_pin = TDI_DRIVEN ? TDI : 1'b1;

  always_ff @(posedge CLK_SYS) begin
    tck_s <= {tck_s[0], TCK};
    tms_s <= {tms_s[0], tms_pin};
    tdi_s <= {tdi_s[0], tdi_pin};
    tck_d <= RST ? 1'b0 : tck_s[1];
  end
  assign tck_rise = tck_s[1] & ~tck_d;
  assign tck_fall = ~tck_s[1] & tck_d;

  // ----------------------------------------------------------------
  // tap controller
  // ----------------------------------------------------------------
  bsp_state_t state_reg;
  bsp_state_t state_next;
  wire        tms = tms_s[1];

  always_comb begin
    unique case (state_reg)
      BSP_RESET:  state_next = tms ? BSP_RESET  : BSP_IDLE;
      BSP_IDLE:   state_next = tms ? BSP_SEL_DR : BSP_IDLE;
      BSP_SEL_DR: state_next = tms ? BSP_SEL_IR : BSP_CAP_DR;
      BSP_CAP_DR: state_next = tms ? BSP_EX1_DR : BSP_SH_DR;
      BSP_SH_DR:  state_next = tms ? BSP_EX1_DR : BSP_SH_DR;
      BSP_EX1_DR: state_next = tms ? BSP_UPD_DR : BSP_PAU_DR;
      BSP_PAU_DR: state_next = tms ? BSP_EX2_DR : BSP_PAU_DR;
      BSP_EX2_DR: state_next = tms ? BSP_UPD_DR : BSP_SH_DR;
      BSP_UPD_DR: state_next = tms ? BSP_SEL_DR : BSP_IDLE;
      BSP_SEL_IR: state_next = tms ? BSP_RESET  : BSP_CAP_IR;
      BSP_CAP_IR: state_next = tms ? BSP_EX1_IR : BSP_SH_IR;
      BSP_SH_IR:  state_next = tms ? BSP_EX1_IR : BSP_SH_IR;
      BSP_EX1_IR: state_next = tms ? BSP_UPD_IR : BSP_PAU_IR;
      BSP_PAU_IR: state_next = tms ? BSP_EX2_IR : BSP_PAU_IR;
      BSP_EX2_IR: state_next = tms ? BSP_UPD_IR : BSP_SH_IR;
      BSP_UPD_IR: state_next = tms ? BSP_SEL_DR : BSP_IDLE;
      default:    state_next = BSP_RESET;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_reg <= BSP_RESET;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  logic [`BSP_IR_LEN-1:0] ir_sh_reg;
  logic [`BSP_IR_LEN-1:0] ir_reg;
  wire  sel_extest = (ir_reg == OP_EXTEST);
  wire  sel_sample = (ir_reg == OP_SAMPLE);
  wire  sel_bsr    = sel_extest | sel_sample;
  wire  tck_r      = tck_rise;
  wire  tdi        = tdi_s[1];

  always_ff @(posedge CLK_SYS) begin
    if (RST || (state_reg == BSP_RESET)) begin  // test-logic reset drops extest at once
      ir_sh_reg <= '0;
      ir_reg    <= OP_BYPASS;
    end else if (tck_r) begin
      if (state_reg == BSP_CAP_IR) ir_sh_reg <= `BSP_IR_CAPTURE;
      if (state_reg == BSP_SH_IR)  ir_sh_reg <= {tdi, ir_sh_reg[`BSP_IR_LEN-1:1]};
      if (state_reg == BSP_UPD_IR) ir_reg    <= ir_sh_reg;
    end
  end

  // ----------------------------------------------------------------
  // bypass and boundary registers
  // ----------------------------------------------------------------
  logic               byp_reg;
  logic [BSR_LEN-1:0] bsr_sh_reg;
  logic [BSR_LEN-1:0] bsr_upd_reg;
  logic [BSR_LEN-1:0] cap_vec;
  logic               snap_push;

  // capture pin levels, with sample or extest alike
  assign cap_vec = PIN_IN;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      byp_reg <= 1'b0;
    end else if (tck_r && !sel_bsr) begin
      if (state_reg == BSP_CAP_DR) byp_reg <= 1'b0;
      if (state_reg == BSP_SH_DR)  byp_reg <= tdi;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      bsr_sh_reg <= '0;
    end else if (tck_r && sel_bsr) begin
      if (state_reg == BSP_CAP_DR) bsr_sh_reg <= cap_vec;
      if (state_reg == BSP_SH_DR)  bsr_sh_reg <= {tdi, bsr_sh_reg[BSR_LEN-1:1]};
    end
  end

  // preload pattern held in update stage
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      bsr_upd_reg <= '0;
    end else if (tck_r && sel_bsr && state_reg == BSP_UPD_DR) begin
      bsr_upd_reg <= bsr_sh_reg;
    end
  end
  assign snap_push = tck_r && sel_bsr && (state_reg == BSP_CAP_DR);

  // ----------------------------------------------------------------
  // pin drive every system clock, serial output on tck falling edge
  // ----------------------------------------------------------------
  wire tdo_next = sel_bsr ? bsr_sh_reg[0] : byp_reg;
  wire shifting = (state_reg == BSP_SH_DR) || (state_reg == BSP_SH_IR);
  wire tdo_src  = (state_reg == BSP_SH_IR) ? ir_sh_reg[0] : tdo_next;

  // extest forces update contents onto pins
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PIN_OUT       <= '0;
      EXTEST_ACTIVE <= 1'b0;
      TDO           <= 1'b0;
      TDO_OE        <= 1'b0;
    end else begin
      PIN_OUT       <= sel_extest ? bsr_upd_reg : CORE_OUT;
      EXTEST_ACTIVE <= sel_extest;
      if (tck_fall) begin
        TDO    <= tdo_src;
        TDO_OE <= shifting;
      end
    end
  end

  // ----------------------------------------------------------------
  // snapshot fifo toward the core
  // ----------------------------------------------------------------
  logic fifo_in_ready;

  // snapshot lost flag if fifo full on capture
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      SNAP_LOST <= 1'b0;
    end else if (snap_push && !fifo_in_ready) begin
      SNAP_LOST <= 1'b1;
    end
  end

  logic [BSR_LEN-1:0] fifo_data;
  logic               fifo_valid;
  logic               take;
  assign take = fifo_valid && (!SNAP_VALID || SNAP_READY);

  bsp_fifo #(.WIDTH(BSR_LEN), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLK_SYS),
    .rst       (RST),
    .in_data   (cap_vec),
    .in_valid  (snap_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (!SNAP_VALID || SNAP_READY)
  );

  // registered stream output
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      SNAP_VALID <= 1'b0;
      SNAP_DATA  <= '0;
    end else if (!SNAP_VALID || SNAP_READY) begin
      SNAP_VALID <= fifo_valid;
      if (take) SNAP_DATA <= fifo_data;
    end
  end
endmodule : bsp_port
`default_nettype wire
